// *** rstc_pkg.sv ***
// Register map, reset values, timing constants and enumerations of the reset controller.
package rstc_pkg;

  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  localparam int unsigned POWERUP_MS      = 72;
  localparam int unsigned POWERUP_CYCLES  = POWERUP_MS * (CLK_HZ / 1000);
  localparam int unsigned OSC_START_TICKS = 1024;
  localparam int unsigned CLEAR_FILTER_NS = 2000;
  localparam int unsigned CLEAR_FILTER_CYCLES =
    (CLEAR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PIN_SETTLE_CYCLES = 1;
  // Window of the analog supply comparator that drives supply_ok.
  localparam int unsigned SUPPLY_DETECT_LO_MV = 1200;
  localparam int unsigned SUPPLY_DETECT_HI_MV = 1700;

  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_W   = ADDR_W - IDX_LSB;

  localparam logic [IDX_W-1:0] REG_PC_LOW  = 10'h002;
  localparam logic [IDX_W-1:0] REG_STATUS  = 10'h003;
  localparam logic [IDX_W-1:0] REG_PC_HIGH = 10'h00a;
  localparam logic [IDX_W-1:0] REG_IRQ_CTL = 10'h00b;
  localparam logic [IDX_W-1:0] REG_OPTION  = 10'h081;
  localparam logic [IDX_W-1:0] REG_A_DIR   = 10'h085;
  localparam logic [IDX_W-1:0] REG_B_DIR   = 10'h086;
  localparam logic [IDX_W-1:0] REG_NV_CTL  = 10'h088;
  localparam logic [IDX_W-1:0] REG_CAUSE   = 10'h090;
  localparam logic [IDX_W-1:0] REG_SCRATCH = 10'h091;

  localparam logic [12:0] PC_RESET_VEC  = 13'h0000;
  localparam logic [12:0] PC_IRQ_VEC    = 13'h0004;
  localparam logic [12:0] PC_STEP       = 13'h0001;
  localparam logic [4:0]  PC_HIGH_RST   = 5'h00;
  localparam logic [7:0]  OPTION_RST    = 8'hff;
  localparam logic [4:0]  A_DIR_RST     = 5'h1f;
  localparam logic [7:0]  B_DIR_RST     = 8'hff;
  localparam logic [7:0]  STATUS_POR    = 8'h18;
  localparam logic [7:0]  STATUS_KEEP   = 8'h1f;
  localparam logic [7:0]  STATUS_SW     = 8'he7;
  localparam logic [7:0]  IRQ_CTL_RST   = 8'h00;
  localparam logic [7:0]  IRQ_CTL_KEEP  = 8'h01;
  localparam logic [4:0]  NV_CTL_RST    = 5'h00;
  localparam logic [4:0]  NV_CTL_SW     = 5'h0f;
  localparam int unsigned STAT_TIMEOUT_BIT   = 4;
  localparam int unsigned STAT_POWERDOWN_BIT = 3;
  localparam int unsigned IRQ_GLOBAL_EN_BIT  = 7;
  localparam int unsigned IRQ_FLAGS_W        = 3;
  localparam int unsigned NV_DONE_BIT        = 4;
  localparam int unsigned NV_ERR_BIT         = 3;
  localparam logic [1:0]  OSC_MODE_RC        = 2'h3;
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  typedef enum logic [2:0] {
    CAUSE_NONE           = 3'b000,
    CAUSE_POWER_ON       = 3'b001,
    CAUSE_CLEAR_RUN      = 3'b010,
    CAUSE_CLEAR_SLEEP    = 3'b011,
    CAUSE_WATCHDOG_RUN   = 3'b100,
    CAUSE_WATCHDOG_WAKE  = 3'b101,
    CAUSE_IRQ_WAKE       = 3'b110
  } rstc_cause_t;

  typedef enum logic [2:0] {
    SEQ_POWER_ON   = 3'b000,
    SEQ_POWERUP    = 3'b001,
    SEQ_OSC_START  = 3'b010,
    SEQ_RUN        = 3'b011,
    SEQ_WAKE_START = 3'b100
  } rstc_seq_t;

endpackage : rstc_pkg

// *** rstc_pin_filter.sv ***
// Three-stage synchroniser with a stability filter for a pin input.
`timescale 1ns/100ps
module rstc_pin_filter #(
  parameter int unsigned STABLE = 1,
  parameter logic        INIT   = 1'b0
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      level
);
  import rstc_pkg::*;

  localparam int unsigned CW = $clog2(STABLE + 1);

  typedef struct packed {
    logic [2:0]    sync;
    logic [CW-1:0] cnt;
    logic          level;
  } rstc_flt_t;

  rstc_flt_t s_r;
  rstc_flt_t s_nxt;

  // A change counts only once the last two stages agree and then stays put long enough.
  always_comb begin
    s_nxt      = s_r;
    s_nxt.sync = {s_r.sync[1:0], pin};
    if (s_r.sync[2] == s_r.sync[1] && s_r.sync[1] != s_r.level) begin
      if (s_r.cnt >= CW'(STABLE - 1)) begin
        s_nxt.level = s_r.sync[1];
        s_nxt.cnt   = '0;
      end else begin
        s_nxt.cnt = s_r.cnt + CW'(1);
      end
    end else begin
      s_nxt.cnt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r.sync  <= {3{INIT}};
      s_r.cnt   <= '0;
      s_r.level <= INIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.level;

endmodule : rstc_pin_filter

// *** rstc_delay.sv ***
// Down counter that times one start-up delay and pulses done at its end.
`timescale 1ns/100ps
module rstc_delay #(
  parameter int unsigned WIDTH = 11
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             start,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] length,
  output logic                  busy,
  output logic                  done
);
  import rstc_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             busy;
    logic             done;
  } rstc_dly_t;

  rstc_dly_t s_r;
  rstc_dly_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (start) begin
      s_nxt.cnt  = length;
      s_nxt.busy = 1'b1;
    end else if (s_r.busy && tick) begin
      if (s_r.cnt <= WIDTH'(1)) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = s_r.busy;
  assign done = s_r.done;

endmodule : rstc_delay

// *** rstc_top.sv ***
// Reset source detection, reset sequencing and reset-state register file behind AXI4-Lite.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/100ps
// How it works
// - Tell six reset and wake causes apart.
// - Clear pin passes a glitch-rejecting filter.
// - Unaffected registers keep contents over resets.
// - Most registers reset on power, clear, watchdog.
// - Watchdog in sleep resumes, registers untouched.
// - Resets load pc zero; wakes step it.
// - Status upper bits take per-cause values.
// - Interrupt wake with global enable vectors.
// - Timeout and powerdown flags show reset cause.
// - Rising supply detection makes power-on reset.
// - Falling supply never causes any reset.
// - Option and port B direction reset ones.
// - Pc low and high latch clear; wake keeps high latch.
// - Interrupt control clears upper seven bits.
// - Port A direction all ones on reset.
// - Nonvolatile control resets; wake clears top.
// - Power-up delay holds reset when enabled.
// - Crystal modes add oscillator start-up delay.
// - Power-on sets timeout and powerdown flags.
module rstc_top #(
  parameter int unsigned POWERUP_CYCLES_P = rstc_pkg::POWERUP_CYCLES
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [rstc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [rstc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        master_clear_n,
  input  wire logic                        supply_ok,
  input  wire logic                        osc_clk_in,
  input  wire logic [1:0]                  osc_mode,
  input  wire logic                        powerup_timer_en_n,
  input  wire logic                        core_sleeping,
  input  wire logic                        watchdog_timer_expired,
  input  wire logic                        wake_irq,
  input  wire logic [rstc_pkg::IRQ_FLAGS_W-1:0] irq_flags,
  input  wire logic                        nv_write_done,
  input  wire logic                        nv_write_active,
  output logic                             core_reset,
  output logic                             core_stall,
  output logic                             wake_resume,
  output logic [12:0]                      pc,
  output logic [7:0]                       option_cfg,
  output logic [4:0]                       a_port_direction,
  output logic [7:0]                       b_port_direction,
  output rstc_pkg::rstc_cause_t            reset_cause
);
  import rstc_pkg::*;

  localparam int unsigned PW = $clog2(POWERUP_CYCLES_P + 1);
  localparam int unsigned OW = $clog2(OSC_START_TICKS + 1);

  typedef struct packed {
    rstc_seq_t        seq;
    rstc_cause_t      cause;
    logic             clear_d;
    logic             supply_d;
    logic             osc_d;
    logic [12:0]      pc;
    logic [7:0]       status;
    logic [4:0]       pc_high;
    logic [7:0]       irq_ctl;
    logic [7:0]       option;
    logic [4:0]       a_dir;
    logic [7:0]       b_dir;
    logic [4:0]       nv_ctl;
    logic [7:0]       scratch;
    logic             core_reset;
    logic             core_stall;
    logic             wake_resume;
    logic             pwr_start;
    logic             osc_start;
    logic             aw_got;
    logic [IDX_W-1:0] aw_idx;
    logic             w_got;
    logic [7:0]       w_data;
    logic             w_lane0;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
  } rstc_state_t;

  rstc_state_t s_r;
  rstc_state_t s_nxt;

  logic clear_lvl;
  logic supply_lvl;
  logic osc_lvl;
  logic pwr_done;
  logic osc_done;

  rstc_pin_filter #(.STABLE(CLEAR_FILTER_CYCLES), .INIT(1'b1)) u_clear_filter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (master_clear_n),
    .level   (clear_lvl)
  );

  rstc_pin_filter #(.STABLE(PIN_SETTLE_CYCLES), .INIT(1'b0)) u_supply_filter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (supply_ok),
    .level   (supply_lvl)
  );

  rstc_pin_filter #(.STABLE(PIN_SETTLE_CYCLES), .INIT(1'b0)) u_osc_filter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (osc_clk_in),
    .level   (osc_lvl)
  );

  rstc_delay #(.WIDTH(PW)) u_powerup_delay (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (s_r.pwr_start),
    .tick    (1'b1),
    .length  (PW'(POWERUP_CYCLES_P)),
    .busy    (),
    .done    (pwr_done)
  );

  rstc_delay #(.WIDTH(OW)) u_osc_start_delay (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (s_r.osc_start),
    .tick    (osc_lvl & ~s_r.osc_d),
    .length  (OW'(OSC_START_TICKS)),
    .busy    (),
    .done    (osc_done)
  );

  // Register values for power-on, clear and running watchdog resets.
  function automatic rstc_state_t apply_reset(rstc_state_t s, rstc_cause_t c, logic nv_busy);
    rstc_state_t r;
    r         = s;
    r.cause   = c;
    r.pc      = PC_RESET_VEC;
    r.pc_high = PC_HIGH_RST;
    r.option  = OPTION_RST;
    r.b_dir   = B_DIR_RST;
    r.a_dir   = A_DIR_RST;
    r.irq_ctl = (c == CAUSE_POWER_ON) ? IRQ_CTL_RST : (IRQ_CTL_RST | (s.irq_ctl & IRQ_CTL_KEEP));
    r.nv_ctl  = NV_CTL_RST;
    // A clear or watchdog reset that cuts a nonvolatile write short leaves the error bit set; power-on clears it.
    r.nv_ctl[NV_ERR_BIT] = (c != CAUSE_POWER_ON) && nv_busy;
    r.status  = s.status & STATUS_KEEP;
    case (c)
      CAUSE_POWER_ON: begin
        r.status = STATUS_POR;
      end
      CAUSE_CLEAR_SLEEP: begin
        r.status[STAT_TIMEOUT_BIT]   = 1'b1;
        r.status[STAT_POWERDOWN_BIT] = 1'b0;
      end
      CAUSE_WATCHDOG_RUN: begin
        r.status[STAT_TIMEOUT_BIT]   = 1'b0;
        r.status[STAT_POWERDOWN_BIT] = 1'b1;
      end
      default: begin
      end
    endcase
    return r;
  endfunction : apply_reset

  // Wake-ups keep register contents; only the pc, cause, status flags and the write-done bit move.
  function automatic rstc_state_t apply_wake(rstc_state_t s, rstc_cause_t c);
    rstc_state_t r;
    r       = s;
    r.cause = c;
    if (c == CAUSE_IRQ_WAKE && s.irq_ctl[IRQ_GLOBAL_EN_BIT]) begin
      r.pc = PC_IRQ_VEC;
    end else begin
      r.pc = s.pc + PC_STEP;
    end
    r.status[STAT_TIMEOUT_BIT]   = (c == CAUSE_IRQ_WAKE);
    r.status[STAT_POWERDOWN_BIT] = 1'b0;
    r.nv_ctl[NV_DONE_BIT]        = 1'b0;
    return r;
  endfunction : apply_wake

  always_comb begin
    logic        crystal;
    logic        clear_live;
    logic        wd_reset;
    logic        mapped;
    rstc_cause_t clr_cause;
    crystal    = (osc_mode != OSC_MODE_RC);
    clear_live = (s_r.seq == SEQ_RUN) || (s_r.seq == SEQ_WAKE_START);
    wd_reset   = 1'b0;
    mapped     = 1'b0;
    clr_cause  = core_sleeping ? CAUSE_CLEAR_SLEEP : CAUSE_CLEAR_RUN;

    s_nxt             = s_r;
    s_nxt.wake_resume = 1'b0;
    s_nxt.pwr_start   = 1'b0;
    s_nxt.osc_start   = 1'b0;
    s_nxt.clear_d     = clear_lvl;
    s_nxt.supply_d    = supply_lvl;
    s_nxt.osc_d       = osc_lvl;

    // Write channel: address and data are taken in either order, answered together.
    if (s_r.awready && s_axi_awvalid) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_idx = s_axi_awaddr[ADDR_W-1:IDX_LSB];
    end
    if (s_r.wready && s_axi_wvalid) begin
      s_nxt.w_got   = 1'b1;
      s_nxt.w_data  = s_axi_wdata[7:0];
      s_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_nxt.aw_got && s_nxt.w_got && !s_r.bvalid) begin
      mapped = 1'b1;
      if (s_nxt.w_lane0) begin
        case (s_nxt.aw_idx)
          REG_PC_LOW:  s_nxt.pc = {s_r.pc_high, s_nxt.w_data};
          REG_STATUS:  s_nxt.status = (s_r.status & ~STATUS_SW) | (s_nxt.w_data & STATUS_SW);
          REG_PC_HIGH: s_nxt.pc_high = s_nxt.w_data[4:0];
          REG_IRQ_CTL: s_nxt.irq_ctl = s_nxt.w_data;
          REG_OPTION:  s_nxt.option = s_nxt.w_data;
          REG_A_DIR:   s_nxt.a_dir = s_nxt.w_data[4:0];
          REG_B_DIR:   s_nxt.b_dir = s_nxt.w_data;
          REG_NV_CTL:  s_nxt.nv_ctl = (s_r.nv_ctl & ~NV_CTL_SW) | (s_nxt.w_data[4:0] & NV_CTL_SW);
          REG_SCRATCH: s_nxt.scratch = s_nxt.w_data;
          REG_CAUSE:   mapped = 1'b1;
          default:     mapped = 1'b0;
        endcase
      end else begin
        case (s_nxt.aw_idx)
          REG_PC_LOW, REG_STATUS, REG_PC_HIGH, REG_IRQ_CTL, REG_OPTION,
          REG_A_DIR, REG_B_DIR, REG_NV_CTL, REG_SCRATCH, REG_CAUSE: mapped = 1'b1;
          default: mapped = 1'b0;
        endcase
      end
      s_nxt.bresp  = mapped ? RESP_OKAY : RESP_SLVERR;
      s_nxt.bvalid = 1'b1;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
    end
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;

    // Read channel: one read at a time, answered the cycle after it is taken.
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_r.arready && s_axi_arvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = RESP_OKAY;
      case (s_axi_araddr[ADDR_W-1:IDX_LSB])
        REG_PC_LOW:  s_nxt.rdata = {24'h000000, s_r.pc[7:0]};
        REG_STATUS:  s_nxt.rdata = {24'h000000, s_r.status};
        REG_PC_HIGH: s_nxt.rdata = {27'h0000000, s_r.pc_high};
        REG_IRQ_CTL: s_nxt.rdata = {24'h000000, s_r.irq_ctl};
        REG_OPTION:  s_nxt.rdata = {24'h000000, s_r.option};
        REG_A_DIR:   s_nxt.rdata = {27'h0000000, s_r.a_dir};
        REG_B_DIR:   s_nxt.rdata = {24'h000000, s_r.b_dir};
        REG_NV_CTL:  s_nxt.rdata = {27'h0000000, s_r.nv_ctl};
        REG_CAUSE:   s_nxt.rdata = {29'h00000000, s_r.cause};
        REG_SCRATCH: s_nxt.rdata = {24'h000000, s_r.scratch};
        default: begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    s_nxt.arready = !s_nxt.rvalid;

    // Hardware flag sets come after software writes so that a set wins over a clear.
    s_nxt.irq_ctl[IRQ_FLAGS_W-1:0] = s_nxt.irq_ctl[IRQ_FLAGS_W-1:0] | irq_flags;
    if (nv_write_done) begin
      s_nxt.nv_ctl[NV_DONE_BIT] = 1'b1;
    end

    case (s_r.seq)
      SEQ_POWER_ON: begin
        if (!powerup_timer_en_n) begin
          s_nxt.pwr_start = 1'b1;
          s_nxt.seq       = SEQ_POWERUP;
        end else if (crystal) begin
          s_nxt.osc_start = 1'b1;
          s_nxt.seq       = SEQ_OSC_START;
        end else begin
          s_nxt.seq = SEQ_RUN;
        end
      end
      SEQ_POWERUP: begin
        if (pwr_done && crystal) begin
          s_nxt.osc_start = 1'b1;
          s_nxt.seq       = SEQ_OSC_START;
        end else if (pwr_done) begin
          s_nxt.seq = SEQ_RUN;
        end
      end
      SEQ_OSC_START: begin
        if (osc_done) begin
          s_nxt.seq = SEQ_RUN;
        end
      end
      SEQ_WAKE_START: begin
        if (osc_done) begin
          s_nxt.seq         = SEQ_RUN;
          s_nxt.wake_resume = 1'b1;
        end
      end
      SEQ_RUN: begin
      end
      default: begin
        s_nxt.seq = SEQ_POWER_ON;
      end
    endcase

    // Only a rising supply starts a power-on reset; a falling one is ignored.
    if (supply_lvl && !s_r.supply_d) begin
      s_nxt     = apply_reset(s_nxt, CAUSE_POWER_ON, nv_write_active);
      s_nxt.seq = SEQ_POWER_ON;
    end else if (!clear_lvl && clear_live) begin
      // The cause is fixed at the falling edge; holding the pin keeps the reset state.
      s_nxt     = apply_reset(s_nxt, s_r.clear_d ? clr_cause : s_r.cause, nv_write_active);
      s_nxt.seq = SEQ_RUN;
    end else if (watchdog_timer_expired && s_r.seq == SEQ_RUN && !core_sleeping) begin
      s_nxt    = apply_reset(s_nxt, CAUSE_WATCHDOG_RUN, nv_write_active);
      wd_reset = 1'b1;
    end else if (s_r.seq == SEQ_RUN && core_sleeping && (watchdog_timer_expired || wake_irq)) begin
      s_nxt = apply_wake(s_nxt, watchdog_timer_expired ? CAUSE_WATCHDOG_WAKE : CAUSE_IRQ_WAKE);
      if (crystal) begin
        s_nxt.osc_start = 1'b1;
        s_nxt.seq       = SEQ_WAKE_START;
      end else begin
        s_nxt.wake_resume = 1'b1;
      end
    end

    // Reset stays asserted during the power-on start-up delays and while the clear pin is low; the wake oscillator delay only stalls.
    s_nxt.core_reset = (s_nxt.seq == SEQ_POWER_ON) || (s_nxt.seq == SEQ_POWERUP) ||
                       (s_nxt.seq == SEQ_OSC_START) || !clear_lvl || wd_reset;
    s_nxt.core_stall = (s_nxt.seq == SEQ_WAKE_START);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r            <= '0;
      s_r.seq        <= SEQ_POWER_ON;
      s_r.cause      <= CAUSE_POWER_ON;
      s_r.clear_d    <= 1'b1;
      s_r.status     <= STATUS_POR;
      s_r.pc         <= PC_RESET_VEC;
      s_r.pc_high    <= PC_HIGH_RST;
      s_r.irq_ctl    <= IRQ_CTL_RST;
      s_r.option     <= OPTION_RST;
      s_r.a_dir      <= A_DIR_RST;
      s_r.b_dir      <= B_DIR_RST;
      s_r.nv_ctl     <= NV_CTL_RST;
      s_r.core_reset <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready    = s_r.awready;
  assign s_axi_wready     = s_r.wready;
  assign s_axi_bresp      = s_r.bresp;
  assign s_axi_bvalid     = s_r.bvalid;
  assign s_axi_arready    = s_r.arready;
  assign s_axi_rdata      = s_r.rdata;
  assign s_axi_rresp      = s_r.rresp;
  assign s_axi_rvalid     = s_r.rvalid;
  assign core_reset       = s_r.core_reset;
  assign core_stall       = s_r.core_stall;
  assign wake_resume      = s_r.wake_resume;
  assign pc               = s_r.pc;
  assign option_cfg       = s_r.option;
  assign a_port_direction = s_r.a_dir;
  assign b_port_direction = s_r.b_dir;
  assign reset_cause      = s_r.cause;

endmodule : rstc_top

// *** rstc_props.sv ***
// Checker of reset sequencing at the controller ports.
`timescale 1ns/100ps
module rstc_props (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  master_clear_n,
  input wire logic                  supply_ok,
  input wire logic                  core_sleeping,
  input wire logic                  watchdog_timer_expired,
  input wire logic                  core_reset,
  input wire logic                  core_stall,
  input wire logic [12:0]           pc,
  input wire logic [7:0]            option_cfg,
  input wire logic [4:0]            a_port_direction,
  input wire logic [7:0]            b_port_direction,
  input wire rstc_pkg::rstc_cause_t reset_cause
);
  import rstc_pkg::*;
  logic [7:0] low_r;
  wire        quiet = !core_reset && !core_stall && master_clear_n;
  // Saturating count of consecutive low samples on the clear pin.
  always_ff @(posedge aclk)
    low_r <= (!aresetn || master_clear_n) ? 8'h00 : low_r + {7'h0, low_r != 8'hff};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wdt_run_a: assert property (
    quiet && !core_sleeping && watchdog_timer_expired |=> core_reset && pc == 13'h0000
    && reset_cause == CAUSE_WATCHDOG_RUN) else $error("bad watchdog reset");
  wdt_wake_a: assert property (
    quiet && core_sleeping && watchdog_timer_expired |=> !core_reset
    && pc == $past(pc) + 13'h0001 && reset_cause == CAUSE_WATCHDOG_WAKE) else $error("bad wake");
  wake_keep_a: assert property (
    quiet && core_sleeping && watchdog_timer_expired |=> $stable(option_cfg)
    && $stable(a_port_direction) && $stable(b_port_direction)) else $error("wake lost registers");
  glitch_rej_a: assert property (
    !core_reset && low_r < 8'h96 && !watchdog_timer_expired && supply_ok && $past(supply_ok, 8)
    |=> !core_reset) else $error("short clear pulse reset the core");
  clear_hold_a: assert property (
    low_r == 8'hff |-> core_reset) else $error("long clear not holding reset");
  reset_vals_a: assert property (
    $rose(core_reset) && !core_sleeping |-> ##[0:1] (option_cfg == 8'hff && pc == 13'h0000
    && a_port_direction == 5'h1f && b_port_direction == 8'hff)) else $error("bad reset state");
  fall_ign_a: assert property (
    ($fell(supply_ok) && !core_reset && low_r == 8'h00) ##1 (!watchdog_timer_expired
    && !supply_ok) [*5] |=> !core_reset) else $error("falling supply caused reset");
  pwr_rise_a: assert property (
    $rose(supply_ok) |-> ##[1:8] (core_reset && reset_cause == CAUSE_POWER_ON))
    else $error("rising supply gave no power-on");
  cover property ($rose(supply_ok));
  cover property (low_r == 8'hff);
  cover property (core_sleeping && watchdog_timer_expired);
endmodule : rstc_props
bind rstc_top rstc_props u_props (.*);

// *** rstc_partner.sv ***
// Supply, clear pin driver and crystal outside the controller.
`timescale 1ns/100ps
module rstc_partner (
  input  wire logic power_on,
  input  wire logic hold_clear,
  output logic      master_clear_n,
  output logic      supply_ok,
  output logic      osc_clk_in
);
  // The pin is pulled low while the supply is absent, so the core cannot start early.
  assign master_clear_n = power_on && !hold_clear;
  assign supply_ok      = power_on;
  initial osc_clk_in = 1'h0;
  // Free running, unrelated to the bus clock and slow enough to be sampled cleanly.
  always #37 osc_clk_in = !osc_clk_in;
endmodule : rstc_partner

// *** tb_top.sv ***
// Bench for the reset controller: bus tasks, register model and reset scenarios.
`timescale 1ns/100ps
module tb_top;
  import rstc_pkg::*;
  logic        aclk = 1'h0, aresetn = 1'h0, power_on = 1'h1, hold_clear = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, core_sleeping = 1'h0;
  logic        watchdog_timer_expired = 1'h0, wake_irq = 1'h0, nv_write_done = 1'h0;
  logic        nv_write_active = 1'h0, powerup_timer_en_n = 1'h0, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, master_clear_n;
  logic        supply_ok, osc_clk_in, core_reset, core_stall, wake_resume;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [2:0]  irq_flags = 3'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr, osc_mode = 2'h0;
  logic [12:0] pc;
  logic [7:0]  option_cfg, b_port_direction;
  logic [4:0]  a_port_direction;
  rstc_cause_t reset_cause;
  int          n_mismatch = 0, compares = 0, cyc = 0, pcm = 0, mdl[int];
  int          rk[6] = '{'h008, 'h028, 'h204, 'h214, 'h218, 'h220};
  int          rvl[6] = '{0, 0, 'hff, 'h1f, 'hff, 0};
  rstc_top #(.POWERUP_CYCLES_P(20)) DUT (.*);
  rstc_partner far_end (.*);
  always #5 aclk = !aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 60000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic finish_test;
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tk(int n);
    repeat (n) @(posedge aclk);
  endtask : tk
  task automatic wr(logic [11:0] a, logic [7:0] d, logic [3:0] s);
    if (s[0]) mdl[a] = d;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      tk(1);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    chk("bresp", RESP_OKAY, s_axi_bresp);
  endtask : wr
  task automatic rd(logic [11:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      tk(1);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
  endtask : rd
  task automatic all_regs;
    foreach (mdl[a]) begin
      rd(12'(a));
      chk($sformatf("reg %h", a), mdl[a], rv);
    end
  endtask : all_regs
  // Model reset; k keeps status low bits and irq flag, zero at power-on.
  task automatic rst_mdl(int st, int cz, int k);
    foreach (rk[i]) mdl[rk[i]] = rvl[i];
    mdl['h00c] = mdl['h00c] & k | st;
    mdl['h02c] = mdl['h02c] & k & 1;
    mdl['h240] = cz;
    pcm = 0;
  endtask : rst_mdl
  task automatic wake(logic irq, int st, int cz, int npc);
    core_sleeping <= 1'h1;
    tk(1);
    wake_irq <= irq;
    watchdog_timer_expired <= !irq;
    tk(1);
    wake_irq <= 1'h0;
    watchdog_timer_expired <= 1'h0;
    while (!wake_resume) tk(1);
    core_sleeping <= 1'h0;
    pcm = npc;
    mdl['h00c] = mdl['h00c] & 'he7 | st;
    mdl['h220] = mdl['h220] & 'h0f;
    mdl['h240] = cz;
    mdl['h008] = npc & 'hff;
    chk("pc", 32'(npc), 32'(pc));
  endtask : wake
  initial begin
    void'($urandom(92403));
    mdl = '{'h00c: 0, 'h02c: 0, 'h244: 0};
    rst_mdl('h18, 1, 0);
    tk(6);
    aresetn <= 1'h1;
    while (core_reset) tk(1);
    all_regs();
    wr(12'h204, 8'($urandom), 4'h0);
    wr(12'h204, 8'($urandom), 4'h1);
    wr(12'h218, 8'($urandom), 4'h1);
    wr(12'h214, 8'($urandom) & 8'h1f, 4'h1);
    wr(12'h244, 8'($urandom), 4'h1);
    wake(1'h0, 'h00, 5, pcm + 1);
    all_regs();
    wr(12'h02c, 8'h80, 4'h1);
    osc_mode <= 2'h3;
    wake(1'h1, 'h10, 6, 4);
    all_regs();
    watchdog_timer_expired <= 1'h1;
    tk(1);
    watchdog_timer_expired <= 1'h0;
    rst_mdl('h08, 4, 7);
    tk(2);
    all_regs();
    hold_clear <= 1'h1;
    tk(50);
    hold_clear <= 1'h0;
    tk(250);
    chk("short clear", 32'h0, 32'(core_reset));
    core_sleeping <= 1'h1;
    hold_clear <= 1'h1;
    tk(300);
    chk("long clear", 32'h1, 32'(core_reset));
    hold_clear <= 1'h0;
    core_sleeping <= 1'h0;
    rst_mdl('h10, 3, 7);
    while (core_reset) tk(1);
    all_regs();
    rd(12'h3fc);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(rr));
    power_on <= 1'h0;
    tk(6);
    chk("supply fall", 32'h0, 32'(core_reset));
    power_on <= 1'h1;
    tk(10);
    chk("supply rise", 32'h1, 32'(core_reset));
    rst_mdl('h18, 1, 0);
    while (core_reset) tk(1);
    all_regs();
    finish_test();
  end
endmodule : tb_top
